// *** dv/qdpi_host_model.sv ***
// Host model that drives a steady square wave onto the step input.
// Assumes the bench clock; the half period is given in clocks.
`timescale 1ns/1ns
`default_nettype none
module qdpi_host_model (
   input wire logic core_clk,
   input wire logic run,
   input wire logic [7:0] half,
   output logic step_pin
);
   logic [7:0] cnt = 8'h00;
   // Toggles at a fixed rate while running and rests low otherwise.
   always @(negedge core_clk) begin
      if (!run) begin
         cnt <= 8'h00;
         step_pin <= 1'b0;
      end else if (cnt == half - 8'h01) begin
         cnt <= 8'h00;
         step_pin <= ~step_pin;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule // qdpi_host_model
`default_nettype wire

// *** dv/test_quiet_decay_pi_config.sv ***
// Self-checking bench for the quiet decay PI configuration block.
// Assumes a 100 MHz clock and a shortened exit gate of 1000 clocks.
`timescale 1ns/1ns
`default_nettype none
module test_quiet_decay_pi_config;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic res_lo = 1'b0;
   logic res_hi = 1'b0;
   logic ms_sel = 1'b0;
   logic pwm_out;
   logic run = 1'b0;
   logic [7:0] reg_rdata;
   logic step_pin;
   logic quiet_active;
   logic [11:0] duty_cycle;
   int n_mismatch = 0;
   int checked = 0;
   int sh[7] = '{5, 6, 7, 8, 9, 4, 0};
   // Free-running 100 MHz clock.
   always #5 core_clk = ~core_clk;
   // Host steps every 80 clocks, about 12 rising edges per gate.
   qdpi_host_model host_u (.core_clk(core_clk), .run(run), .half(8'h28),
      .step_pin(step_pin));
   // Target exceeds sensed current by 10 counts.
   qdpi_top #(.GATE_CYC(1000)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .step_pin(step_pin),
      .resolution_pin_low(res_lo), .resolution_pin_high(res_hi),
      .microstep_from_reg(ms_sel), .microstep_reg_shift(4'h0),
      .target_current(12'h014), .sensed_current(12'h00a),
      .quiet_active(quiet_active), .pwm_out(pwm_out),
      .duty_cycle(duty_cycle));
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Compares one value and reports a mismatch at once.
   task automatic check(input string what, input logic [11:0] e, g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   // One register write, strobe held for a single edge.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   // One register read; data is registered on the read edge and checked half a cycle later.
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      check("reg_rdata", {4'h0, e}, {4'h0, reg_rdata});
   endtask
   // Bounded wait for the duty cycle to leave zero.
   task automatic wait_duty();
      int i;
      for (i = 0; i < 5000 && duty_cycle === 12'h000; i++) begin
         @(negedge core_clk);
      end
      if (i == 5000) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   // Main sequence: reset values, read back, gain dividers, exit.
   initial begin
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      rd(6'h31, 8'h00);
      rd(6'h32, 8'h00);
      rd(6'h33, 8'h00);
      rd(6'h34, 8'h00);
      rd(6'h35, 8'hff);
      rd(6'h30, 8'h00);
      wr(6'h32, 8'hff);
      rd(6'h32, 8'hff);
      wr(6'h33, 8'h80);
      rd(6'h33, 8'h80);
      wr(6'h32, 8'h7f);
      for (int c = 0; c < 7; c++) begin
         wr(6'h31, 8'h00);
         wr(6'h34, 8'(c * 17));
         rd(6'h34, 8'(c * 17));
         check("duty_off", 12'h000, duty_cycle);
         check("pwm_off", 12'h000, {11'h000, pwm_out});
         wr(6'h31, 8'h0d);
         check("active", 12'h001, {11'h000, quiet_active});
         wait_duty();
         check("duty", 12'(1270 >> sh[c]), duty_cycle);
         check("pwm_on", 12'h001, {11'h000, pwm_out});
      end
      wr(6'h35, 8'h01);
      run = 1'b1;
      repeat (2500) @(negedge core_clk);
      check("exit", 12'h000, {11'h000, quiet_active});
      res_lo = 1'b1;
      repeat (2500) @(negedge core_clk);
      check("stay", 12'h001, {11'h000, quiet_active});
      // Register resolution of full steps brings the exit back.
      ms_sel = 1'b1;
      repeat (2500) @(negedge core_clk);
      check("reg_res_exit", 12'h000, {11'h000, quiet_active});
      // Finest pin resolution raises the limit well above the step count.
      ms_sel = 1'b0;
      res_hi = 1'b1;
      repeat (2500) @(negedge core_clk);
      check("pin_res_stay", 12'h001, {11'h000, quiet_active});
      finish_test();
   end
endmodule // test_quiet_decay_pi_config
`default_nettype wire

// *** hdl/qdpi_pkg.sv ***
// Types shared by the quiet decay PI configuration block.
// Assumes nothing of its surroundings.
package qdpi_pkg;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] kp;
      logic [7:0] ki;
      logic [7:0] div;
      logic [7:0] thr;
      logic [7:0] rdata;
      logic [1:0] step_s;
      logic [1:0] res0_s;
      logic [1:0] res1_s;
      logic step_prev;
      logic [31:0] steps;
      logic [31:0] gate;
      logic exited;
      logic [11:0] pwm_cnt;
      logic [11:0] duty;
      logic signed [23:0] integ;
   } qdpi_state_s;
endpackage

// *** hdl/qdpi_regs.svh ***
// Register map, field positions, reset values and timing for quiet decay.
// Assumes a 100 MHz core clock, as fixed here in QD_CLK_HZ.
// Contract
// RQ1: Hold a 7-bit proportional gain code, 0 to 127, as raw P gain.
// RQ2: Hold a 7-bit integral gain code, 0 to 127, reset zero, as raw I gain.
// RQ3: Integral divider field bits 6-4 selects /32,/64,/128,/256,/512,/16,/1.
// RQ4: Proportional divider field in low bits uses the same encoding.
// RQ5: Leave quiet decay when coil sine frequency exceeds threshold, 2 Hz/count.
// RQ6: Threshold resets to all ones; gain and divider registers reset to zero.
// RQ7: Host never writes zero into the exit threshold.
// RQ8: Bit 7 of gain registers is read/write, resets zero, no effect.
// RQ9: Host drives step with steady square wave at the step rate.
// RQ10: Host computes step rate from rpm, step angle and microstep fraction.
// RQ11: Resolution comes from two pins or register bits; host scales rate.
// RQ12: Quiet decay regulates only while enable bit 0 of control is one.
// RQ13: Quiet PWM rate field: 00 25 kHz, 01 33, 10 42, 11 50 kHz.
// RQ14: Each PWM period, update duty by P term plus accumulated I term.
`ifndef QDPI_REGS_SVH
`define QDPI_REGS_SVH
`define QD_ADDR_CTRL 6'h31
`define QD_ADDR_KP 6'h32
`define QD_ADDR_KI 6'h33
`define QD_ADDR_DIV 6'h34
`define QD_ADDR_THR 6'h35
`define QD_RST_ZERO 8'h00
`define QD_RST_THR 8'hff
`define QD_EN_BIT 0
`define QD_PWM_LSB 2
`define QD_KP_DIV_LSB 0
`define QD_KI_DIV_LSB 4
`define QD_CLK_HZ 100000000
`define QD_PWM_HZ0 25000
`define QD_PWM_HZ1 33000
`define QD_PWM_HZ2 42000
`define QD_PWM_HZ3 50000
`define QD_GATE_MS 500
`define QD_GATE_CYC ((`QD_CLK_HZ / 1000) * `QD_GATE_MS)
`define QD_STEPS_PER_SINE 2
`endif

// *** hdl/qdpi_top.sv ***
// Quiet decay PI current controller, its register file and exit detector.
// Assumes a register port decoded from the serial interface, same clock.
`include "qdpi_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module qdpi_top #(
   parameter int GATE_CYC = `QD_GATE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic step_pin,
   input wire logic resolution_pin_low,
   input wire logic resolution_pin_high,
   input wire logic microstep_from_reg,
   input wire logic [3:0] microstep_reg_shift,
   input wire logic [11:0] target_current,
   input wire logic [11:0] sensed_current,
   output logic quiet_active,
   output logic pwm_out,
   output logic [11:0] duty_cycle
);
   qdpi_pkg::qdpi_state_s st;
   qdpi_pkg::qdpi_state_s next_st;
   logic [11:0] period;
   logic [3:0] p_shift;
   logic [3:0] i_shift;
   logic [3:0] res_shift;
   logic [39:0] exit_limit;
   logic signed [12:0] err;
   logic signed [31:0] p_term;
   logic signed [31:0] i_term;
   logic signed [31:0] duty_sum;
   logic signed [23:0] next_integ;
   logic gate_end;

   // Maps a divider code to a right shift; the spare code acts undivided.
   function automatic logic [3:0] div_shift(input logic [2:0] code);
      case (code)
         3'h0: div_shift = 4'h5;
         3'h1: div_shift = 4'h6;
         3'h2: div_shift = 4'h7;
         3'h3: div_shift = 4'h8;
         3'h4: div_shift = 4'h9;
         3'h5: div_shift = 4'h4;
         default: div_shift = 4'h0;
      endcase
   endfunction

   // Period in clock cycles of each quiet decay PWM rate.
   always_comb begin
      case (st.ctrl[`QD_PWM_LSB +: 2]) // RQ13
         2'h0: period = 12'(`QD_CLK_HZ / `QD_PWM_HZ0);
         2'h1: period = 12'(`QD_CLK_HZ / `QD_PWM_HZ1);
         2'h2: period = 12'(`QD_CLK_HZ / `QD_PWM_HZ2);
         default: period = 12'(`QD_CLK_HZ / `QD_PWM_HZ3);
      endcase
   end

   // Effective gains are raw codes shifted down by their divider fields.
   assign i_shift = div_shift(st.div[`QD_KI_DIV_LSB +: 3]); // RQ3
   assign p_shift = div_shift(st.div[`QD_KP_DIV_LSB +: 3]); // RQ4

   // Resolution as a shift of microsteps per full step.
   assign res_shift = microstep_from_reg ? microstep_reg_shift :
      {1'b0, st.res1_s[1], st.res0_s[1], 1'b0}; // RQ11

   // Steps per gate that match the threshold frequency at this resolution.
   assign exit_limit = ({32'h0, st.thr} << `QD_STEPS_PER_SINE) << res_shift;
   assign gate_end = st.gate >= 32'(GATE_CYC - 1);

   // Error and the two PI terms; bit 7 of the gain registers is ignored.
   assign err = $signed({1'b0, target_current}) -
      $signed({1'b0, sensed_current}); // RQ14
   assign next_integ = st.integ + 24'(err);
   assign p_term = ($signed({25'h0, st.kp[6:0]}) * 32'(err))
      >>> p_shift; // RQ1
   assign i_term = ($signed({25'h0, st.ki[6:0]}) * 32'(next_integ))
      >>> i_shift; // RQ2
   assign duty_sum = $signed({20'h0, st.duty}) + p_term + i_term;

   // Next state: registers, synchronisers, exit detector and PI loop.
   always_comb begin
      next_st = st;
      next_st.step_s = {st.step_s[0], step_pin};
      next_st.res0_s = {st.res0_s[0], resolution_pin_low};
      next_st.res1_s = {st.res1_s[0], resolution_pin_high};
      next_st.step_prev = st.step_s[1];
      if (reg_wr) begin
         case (reg_addr)
            `QD_ADDR_CTRL: next_st.ctrl = reg_wdata;
            `QD_ADDR_KP: next_st.kp = reg_wdata; // RQ8
            `QD_ADDR_KI: next_st.ki = reg_wdata; // RQ8
            `QD_ADDR_DIV: next_st.div = reg_wdata;
            `QD_ADDR_THR: next_st.thr = reg_wdata; // RQ7
            default: next_st.rdata = st.rdata;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `QD_ADDR_CTRL: next_st.rdata = st.ctrl;
            `QD_ADDR_KP: next_st.rdata = st.kp;
            `QD_ADDR_KI: next_st.rdata = st.ki;
            `QD_ADDR_DIV: next_st.rdata = st.div;
            `QD_ADDR_THR: next_st.rdata = st.thr;
            default: next_st.rdata = `QD_RST_ZERO;
         endcase
      end
      // Rising step edges counted over a fixed gate decide the exit.
      if (gate_end) begin
         next_st.gate = 32'h0;
         next_st.steps = 32'h0;
         next_st.exited = {8'h0, st.steps} > exit_limit; // RQ5
      end else begin
         next_st.gate = st.gate + 32'h1;
         if (st.step_s[1] && !st.step_prev) begin
            next_st.steps = st.steps + 32'h1;
         end
      end
      // PWM counter with a duty update once per period.
      if (st.pwm_cnt >= period - 12'h1) begin
         next_st.pwm_cnt = 12'h0;
         if (quiet_active) begin
            next_st.integ = next_integ; // RQ14
            if (duty_sum < 0) begin
               next_st.duty = 12'h0;
            end else if (duty_sum > $signed({20'h0, period})) begin
               next_st.duty = period;
            end else begin
               next_st.duty = duty_sum[11:0];
            end
         end
      end else begin
         next_st.pwm_cnt = st.pwm_cnt + 12'h1;
      end
      // Leaving quiet decay drops the loop state for a clean restart.
      if (!quiet_active) begin
         next_st.duty = 12'h0;
         next_st.integ = 24'sh0;
      end
   end

   // State register with synchronous reset; gains and dividers clear and
   // the exit threshold returns to all ones.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '0;
         st.thr <= `QD_RST_THR; // RQ6
      end else begin
         st <= next_st;
      end
   end

   // Outputs.
   assign quiet_active = st.ctrl[`QD_EN_BIT] && !st.exited; // RQ12
   assign pwm_out = quiet_active && (st.pwm_cnt < st.duty);
   assign duty_cycle = st.duty;
   assign reg_rdata = st.rdata;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_write(logic [5:0] a);
      reg_wr && reg_addr == a;
   endsequence
   sequence s_gate_over;
      gate_end && ({8'h0, st.steps} > exit_limit);
   endsequence
   sequence s_step_rise;
      st.step_s[1] && !st.step_prev;
   endsequence

   AST_RESET_VALUES: assert property ($past(!rst_n) |-> // RQ6
      st.thr == `QD_RST_THR && st.kp == `QD_RST_ZERO && st.div == 8'h00)
      else $error("reset values wrong");
   AST_KP_STORE: assert property (s_write(`QD_ADDR_KP) |=> // RQ1
      st.kp == $past(reg_wdata)) else $error("gain write lost");
   AST_KI_READ: assert property (s_write(`QD_ADDR_KI) ##1 !reg_wr ##1 // RQ8
      (reg_rd && reg_addr == `QD_ADDR_KI && !reg_wr) |=>
      reg_rdata == $past(reg_wdata, 3)) else $error("readback wrong");
   AST_I_SHIFT: assert property (st.div[6:4] == 3'h5 |-> // RQ3
      i_shift == 4'h4) else $error("integral divider wrong");
   AST_P_SHIFT: assert property (st.div[2:0] == 3'h6 |-> // RQ4
      p_shift == 4'h0) else $error("proportional divider wrong");
   AST_EXIT: assert property (s_gate_over |=> !quiet_active ##1 // RQ5
      !quiet_active) else $error("exit missed");
   AST_DISABLED: assert property (!st.ctrl[0] |=> // RQ12
      duty_cycle == 12'h0 && !pwm_out) else $error("active while off");
   AST_PWM_RATE: assert property (st.ctrl[3:2] == 2'h3 && // RQ13
      $stable(st.ctrl) |-> st.pwm_cnt <= 12'd2000)
      else $error("pwm period wrong");
   AST_DUTY_HOLD: assert property (quiet_active && // RQ14
      st.pwm_cnt != 12'h0 && $past(quiet_active) |->
      $stable(duty_cycle)) else $error("duty moved mid period");

   // A threshold write lands on the next edge.
   AST_THR_STORE: assert property (s_write(`QD_ADDR_THR) |=> // RQ5
      st.thr == $past(reg_wdata)) else $error("threshold write lost");
   // A divider write lands on the next edge.
   AST_DIV_STORE: assert property (s_write(`QD_ADDR_DIV) |=> // RQ3
      st.div == $past(reg_wdata)) else $error("divider write lost");
   // Read data stands until the next read strobe.
   AST_RDATA_HOLD: assert property (!reg_rd |=> // RQ8
      $stable(reg_rdata))
      else $error("read data moved without a read");
   // Addresses outside the map read back as zero.
   AST_UNMAPPED_READ: assert property (reg_rd && // RQ8
      (reg_addr < `QD_ADDR_CTRL || reg_addr > `QD_ADDR_THR) |=>
      reg_rdata == `QD_RST_ZERO) else $error("unmapped read not zero");
   // The integral is cleared while regulation is off.
   AST_INTEG_CLEAR: assert property (!quiet_active |=> // RQ12
      st.integ == 24'sh0) else $error("integral kept while off");
   // Each synchronised rising step edge inside a gate adds one count.
   AST_STEP_COUNT: assert property (s_step_rise ##0 !gate_end |=> // RQ5
      st.steps == $past(st.steps) + 32'h1) else $error("step not counted");
endmodule // qdpi_top
`default_nettype wire
